// ===== src/compare_skip_instruction_exec.sv
// executor for complement and compare-and-skip instructions
`timescale 1ns/1ns
`default_nettype none
`include "cse_defs.svh"
module compare_skip_instruction_exec
  import cse_pkg::*;
#(
  parameter int Q_DIV = `CSE_QDIV
) (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        rstn,
  // fetch side
  input  wire logic [15:0] instr_word,
  input  wire logic        next_two_word,
  input  wire logic        ext_set_en,
  output logic             slot_end,
  output logic             flush,
  output qphase_t          phase,
  // addressing sources
  input  wire logic [3:0]  bank_select_register,
  input  wire logic [11:0] fsr2,
  // data memory
  output logic [11:0]      mem_addr,
  output logic             mem_rd_en,
  input  wire logic [7:0]  mem_rd_data,
  output logic             mem_wr_en,
  output logic [7:0]       mem_wr_data,
  // working register and flags
  input  wire logic [7:0]  w_in,
  output logic             w_wr_en,
  output logic [7:0]       w_wr_data,
  output logic             flag_wr_en,
  output logic             flag_n,
  output logic             flag_z
);
  // =====================================================================
  // reset release
  logic rst_meta_r;
  logic rst_n_s;
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rst_meta_r <= 1'b0;
      rst_n_s    <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n_s    <= rst_meta_r;
    end
  end

  // =====================================================================
  // quarter phase divider
  logic [7:0] div_r;
  qphase_t    phase_r;
  wire        q_en = (div_r == 8'(Q_DIV - 1));
  always_ff @(posedge core_clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      div_r   <= 8'h00;
      phase_r <= PH_Q1;
    end else begin
      div_r <= q_en ? 8'h00 : div_r + 8'h01;
      if (q_en) phase_r <= qphase_t'(phase_r + 2'h1);
    end
  end

  // =====================================================================
  // state and operand registers
  slot_t       slot_r;
  slot_t       slot_nxt;
  logic [15:0] instr_r;
  logic        two_word_r;
  logic [11:0] addr_r;
  logic [7:0]  f_r;
  logic [7:0]  w_r;
  logic [7:0]  inv_r;
  logic        zero_r;
  cmp_if       cmp ();

  unsigned_compare u_cmp (.c(cmp));

  // =====================================================================
  // decode
  wire  executing = (slot_r == SLOT_EXEC);
  wire  at_q1     = q_en && (phase_r == PH_Q1) && executing;
  wire  at_q2     = q_en && (phase_r == PH_Q2) && executing;
  wire  at_q3     = q_en && (phase_r == PH_Q3) && executing;
  wire  in_q4     = executing && (phase_r == PH_Q4);
  wire  bank_bit  = instr_r[`CSE_BIT_BANK];
  wire  dest_bit  = instr_r[`CSE_BIT_DEST];
  wire [7:0] f_lit = instr_r[7:0];
  op_t  op;
  assign op = (instr_r[15:10] == `CSE_OPC_COMPLEMENT_REGISTER)   ? OP_COMPLEMENT_REGISTER   :
              (instr_r[15:9]  == `CSE_OPC_CPF_EQ) ? OP_CMP_EQ :
              (instr_r[15:9]  == `CSE_OPC_CPF_GT) ? OP_CMP_GT :
              (instr_r[15:9]  == `CSE_OPC_CPF_LT) ? OP_CMP_LT : OP_NONE;
  wire  is_cmp    = (op == OP_CMP_EQ) || (op == OP_CMP_GT) || (op == OP_CMP_LT);
  wire  is_known  = (op != OP_NONE);

  // =====================================================================
  // effective address
  wire        use_index = ext_set_en && !bank_bit && (f_lit <= `CSE_INDEX_LIMIT); // RULE7
  wire [11:0] idx_addr  = fsr2 + {4'h0, f_lit}; // RULE7
  wire [3:0]  acc_bank  = (f_lit >= `CSE_ACCESS_SPLIT) ? `CSE_ACCESS_HI_BNK : `CSE_ACCESS_LO_BNK;
  wire [11:0] eff_addr  = use_index ? idx_addr :
                          bank_bit  ? {bank_select_register, f_lit} : // RULE6
                                      {acc_bank, f_lit}; // RULE6

  // =====================================================================
  // skip decision; the flow change is the only effect of a compare
  assign cmp.f_val = f_r;
  assign cmp.w_val = w_r;
  wire   skip_take = ((op == OP_CMP_EQ) && cmp.eq) || // RULE1
                     ((op == OP_CMP_GT) && cmp.gt) || // RULE8
                     ((op == OP_CMP_LT) && cmp.lt); // RULE9
  wire   q4_end    = q_en && (phase_r == PH_Q4);

  always_comb begin
    slot_nxt = slot_r;
    if (q4_end) begin
      case (slot_r)
        SLOT_EXEC:   slot_nxt = skip_take ? SLOT_SKIP_A : SLOT_EXEC; // RULE3
        SLOT_SKIP_A: slot_nxt = two_word_r ? SLOT_SKIP_B : SLOT_EXEC; // RULE4
        SLOT_SKIP_B: slot_nxt = SLOT_EXEC;
        default:     slot_nxt = SLOT_EXEC;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      slot_r     <= SLOT_EXEC;
      instr_r    <= 16'h0000;
      two_word_r <= 1'b0;
      addr_r     <= 12'h000;
      f_r        <= 8'h00;
      w_r        <= 8'h00;
      inv_r      <= 8'h00;
      zero_r     <= 1'b0;
    end else begin
      slot_r <= slot_nxt;
      if (at_q1) instr_r <= instr_word;
      if (at_q1) two_word_r <= next_two_word;
      if (at_q2) addr_r <= eff_addr;
      if (at_q3) f_r <= mem_rd_data;
      if (at_q3) w_r <= w_in;
      if (at_q3) inv_r <= ~mem_rd_data; // RULE10
      if (at_q3) zero_r <= (mem_rd_data == 8'hFF);
    end
  end

  // =====================================================================
  // outputs; strobes only in an executing slot, so skipped slots stay silent
  // result is taken with the operand, so write data and flags leave straight from flops
  wire       wr_slot = q_en && in_q4 && (op == OP_COMPLEMENT_REGISTER); // RULE11
  assign mem_addr    = addr_r;
  assign mem_rd_en   = executing && is_known && (phase_r == PH_Q3); // RULE5
  assign mem_wr_en   = wr_slot && dest_bit; // RULE10
  assign w_wr_en     = wr_slot && !dest_bit; // RULE10
  assign flag_wr_en  = wr_slot; // RULE2
  assign mem_wr_data = inv_r;
  assign w_wr_data   = inv_r;
  assign flag_n      = inv_r[7];
  assign flag_z      = zero_r;
  assign slot_end    = q4_end;
  assign flush       = !executing; // RULE5
  assign phase       = phase_r;

  // =====================================================================
  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n_s);

  eq_skip_a: assert property (q4_end && executing && op == OP_CMP_EQ && cmp.eq |=> slot_r == SLOT_SKIP_A) // RULE1
    else $error("equal compare did not skip");
  no_flags_a: assert property (is_cmp |-> !flag_wr_en) // RULE2
    else $error("compare touched flags");
  one_nop_a: assert property (q4_end && slot_r == SLOT_SKIP_A && !two_word_r |=> slot_r == SLOT_EXEC) // RULE3
    else $error("single skip lasted too long");
  two_nop_a: assert property (q4_end && slot_r == SLOT_SKIP_A && two_word_r |=> slot_r == SLOT_SKIP_B) // RULE4
    else $error("two-word skip missed second slot");
  skip_quiet_a: assert property (flush |-> !mem_wr_en && !w_wr_en && !flag_wr_en && !mem_rd_en) // RULE5
    else $error("activity in a skipped slot");
  bank_sel_a: assert property (at_q2 && bank_bit |=> addr_r[11:8] == $past(bank_select_register)) // RULE6
    else $error("bank bits not from bank register");
  indexed_a: assert property (at_q2 && use_index |=> addr_r == $past(idx_addr)) // RULE7
    else $error("indexed offset address wrong");
  gt_only_a: assert property (q4_end && executing && op == OP_CMP_GT && !cmp.gt |=> slot_r == SLOT_EXEC) // RULE8
    else $error("greater compare skipped wrongly");
  lt_skip_a: assert property (q4_end && executing && op == OP_CMP_LT && cmp.lt |=> slot_r == SLOT_SKIP_A) // RULE9
    else $error("less compare did not skip");
  complement_register_dest_a: assert property (w_wr_en |-> w_wr_data == ~f_r && !dest_bit && !mem_wr_en) // RULE10
    else $error("complement result or destination wrong");
  cmp_nowr_a: assert property (is_cmp |-> !mem_wr_en && !w_wr_en) // RULE11
    else $error("compare wrote data");
  eq_only_a: assert property (q4_end && executing && op == OP_CMP_EQ && !cmp.eq |=> slot_r == SLOT_EXEC) // RULE1
    else $error("equal compare skipped wrongly");
  gt_skip_a: assert property (q4_end && executing && op == OP_CMP_GT && cmp.gt |=> slot_r == SLOT_SKIP_A) // RULE8
    else $error("greater compare did not skip");
  lt_only_a: assert property (q4_end && executing && op == OP_CMP_LT && !cmp.lt |=> slot_r == SLOT_EXEC) // RULE9
    else $error("less compare skipped wrongly");
  cmp_math_a: assert property (is_cmp && q4_end |-> cmp.lt == (f_r < w_r) && cmp.eq == (f_r == w_r)) // RULE2
    else $error("compare result is not unsigned");
  no_skip_a: assert property (q4_end && executing && !is_cmp |=> slot_r == SLOT_EXEC) // RULE3
    else $error("non-compare caused a skip");
  skip_last_a: assert property (q4_end && slot_r == SLOT_SKIP_B |=> slot_r == SLOT_EXEC) // RULE4
    else $error("second skipped slot did not end");
  flush_hold_a: assert property (flush && !q4_end |=> flush) // RULE5
    else $error("skipped slot cut short");
  phase_wrap_a: assert property (q4_end |=> phase_r == PH_Q1) // RULE5
    else $error("quarter phase did not wrap");
  access_bank_a: assert property (at_q2 && !bank_bit && !use_index |=> addr_r[7:0] == $past(f_lit)) // RULE6
    else $error("access bank offset wrong");
  complement_register_flag_a: assert property (flag_wr_en |-> flag_n == w_wr_data[7] && flag_z == (w_wr_data == 8'h00)) // RULE10
    else $error("complement flags wrong");
  complement_register_mem_a: assert property (mem_wr_en |-> mem_wr_data == ~f_r && dest_bit && !w_wr_en) // RULE10
    else $error("complement write to register wrong");

  skip_seen_c:  cover property (q4_end && executing && skip_take);
  two_skip_c:   cover property (slot_r == SLOT_SKIP_B);
  complement_register_mem_c:   cover property (mem_wr_en);
  complement_register_w_c:     cover property (w_wr_en);
  gt_skip_c:    cover property (q4_end && executing && op == OP_CMP_GT && cmp.gt);
endmodule // compare_skip_instruction_exec
`default_nettype wire

// ===== src/cse_defs.svh
// constants for the compare/skip and complement execution block
//
// Behaviour
// [RULE1] equality compare discards the fetched next instruction when byte equals working register
// [RULE2] compares use unsigned subtraction and never touch any status flag
// [RULE3] a taken skip replaces the next instruction with a no-operation slot
// [RULE4] skipping a two-word instruction makes the compare take three slots
// [RULE5] every skipped slot does nothing in all four phases and writes nothing
// [RULE6] bank bit zero selects access bank, one takes bank bits from register
// [RULE7] extended set, bank bit zero, address up to 5Fh uses indexed offset
// [RULE8] greater compare skips only when unsigned byte exceeds working register
// [RULE9] less compare skips only when unsigned byte is below working register
// [RULE10] complement inverts the byte, destination bit picks target, only N and Z
// [RULE11] compares never modify the working register or the data byte
`ifndef CSE_DEFS_SVH
`define CSE_DEFS_SVH

// =====================================================================
// opcode fields
`define CSE_OPC_COMPLEMENT_REGISTER      6'h07
`define CSE_OPC_CPF_EQ    7'h31
`define CSE_OPC_CPF_GT    7'h32
`define CSE_OPC_CPF_LT    7'h30
`define CSE_BIT_DEST      9
`define CSE_BIT_BANK      8

// =====================================================================
// addressing
`define CSE_INDEX_LIMIT   8'h5F
`define CSE_ACCESS_SPLIT  8'h60
`define CSE_ACCESS_LO_BNK 4'h0
`define CSE_ACCESS_HI_BNK 4'hF

// =====================================================================
// timing: core clocks per quarter phase
`define CSE_QDIV          1

`endif

// ===== src/cse_pkg.sv
// types shared by the execution block
package cse_pkg;
  typedef enum logic [1:0] {PH_Q1, PH_Q2, PH_Q3, PH_Q4} qphase_t;
  typedef enum logic [1:0] {SLOT_EXEC, SLOT_SKIP_A, SLOT_SKIP_B} slot_t;
  typedef enum logic [2:0] {OP_NONE, OP_COMPLEMENT_REGISTER, OP_CMP_EQ, OP_CMP_GT, OP_CMP_LT} op_t;
endpackage

// ===== src/cmp_if.sv
// operand and result bundle between executor and comparator
`timescale 1ns/1ns
`default_nettype none
interface cmp_if;
  logic [7:0] f_val;
  logic [7:0] w_val;
  logic       eq;
  logic       gt;
  logic       lt;
  modport exec (output f_val, output w_val, input eq, input gt, input lt);
  modport unit (input f_val, input w_val, output eq, output gt, output lt);
endinterface // cmp_if
`default_nettype wire

// ===== src/unsigned_compare.sv
// unsigned byte comparator by subtraction
`timescale 1ns/1ns
`default_nettype none
module unsigned_compare (
  cmp_if.unit c
);
  // =====================================================================
  // subtraction with borrow out; no flag is produced here at all
  wire [8:0] diff = {1'b0, c.f_val} - {1'b0, c.w_val}; // RULE2
  assign c.eq = (diff == 9'h000);
  assign c.lt = diff[8];
  assign c.gt = !diff[8] && (diff != 9'h000);
endmodule // unsigned_compare
`default_nettype wire

// ===== dv/data_mem_model.sv
// banked data memory partner for the execution block
`timescale 1ns/1ns
`default_nettype none
module data_mem_model (
  // clock
  input  wire logic        core_clk,
  // access port
  input  wire logic [11:0] mem_addr,
  input  wire logic        mem_rd_en,
  output logic [7:0]       mem_rd_data,
  input  wire logic        mem_wr_en,
  input  wire logic [7:0]  mem_wr_data
);
  // ====================
  // storage preset so each byte follows from its address
  logic [7:0] mem [4096];
  initial for (int i = 0; i < 4096; i++) mem[i] = 8'(i) ^ {2{4'(i >> 8)}};
  always @(posedge core_clk) if (mem_wr_en) mem[mem_addr] <= mem_wr_data;
  // idle port shows the inverse so stale data never passes for a read
  assign mem_rd_data = mem_rd_en ? mem[mem_addr] : ~mem[mem_addr];
endmodule // data_mem_model
`default_nettype wire

// ===== dv/compare_skip_instruction_exec_tb_top.sv
// self-checking bench for the compare/skip and complement executor
`timescale 1ns/1ns
`default_nettype none
module compare_skip_instruction_exec_tb_top;
  import cse_pkg::*;
  // ====================
  // stimulus and observed values
  logic core_clk = 1'b0, rstn = 1'b0, two = 1'b0, ext = 1'b0;
  logic [15:0] iw = 16'h0000;
  logic [3:0]  bank = 4'h3, mw, ww, fw, fl;
  logic [7:0]  w = 8'h00, rd, wd, md, dat, f, wv;
  logic [11:0] addr, got_addr;
  logic        send, mwe, wwe, fwe, fn, fz, sk, flush, mrd;
  logic [1:0]  nz, ph, eph;
  int n_errors = 0, tests_run = 0;
  always #4 core_clk = ~core_clk;
  compare_skip_instruction_exec i_compare_skip_instruction_exec (
    .core_clk(core_clk), .rstn(rstn), .instr_word(iw), .next_two_word(two), .ext_set_en(ext),
    .slot_end(send), .flush(flush), .phase(ph), .bank_select_register(bank), .fsr2(12'h123),
    .mem_addr(addr), .mem_rd_en(mrd), .mem_rd_data(rd), .mem_wr_en(mwe), .mem_wr_data(md),
    .w_in(w), .w_wr_en(wwe), .w_wr_data(wd), .flag_wr_en(fwe), .flag_n(fn), .flag_z(fz));
  data_mem_model i_data_mem_model (.core_clk(core_clk), .mem_addr(addr), .mem_rd_en(mrd),
    .mem_rd_data(rd), .mem_wr_en(mwe), .mem_wr_data(md));
  // ====================
  // shared tasks
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // sampling at the edge sees pre-edge values, so the launch edge never races
  task automatic issue(input logic [15:0] i, input logic t, input int slots);
    int ses;
    iw <= i;
    two <= t;
    {ses, fl, mw, ww, fw} = '0;
    {got_addr, dat, nz, eph} = 'x;
    for (int k = 0; k < 40 && ses < slots; k++) begin
      @(posedge core_clk);
      if (mrd === 1'b1) got_addr = addr;
      if (flush === 1'b1) fl = fl + 4'h1;
      if (send === 1'b1) begin
        ses++;
        eph = ph;
      end
      if (mwe === 1'b1) begin mw = mw + 4'h1; dat = md; end
      if (wwe === 1'b1) begin ww = ww + 4'h1; dat = wd; end
      if (fwe === 1'b1) begin fw = fw + 4'h1; nz = {fn, fz}; end
    end
    if (ses < slots) begin
      n_errors++;
      end_of_test();
    end
  endtask
  function automatic logic [7:0] pat(input logic [11:0] a);
    return a[7:0] ^ {a[11:8], a[11:8]};
  endfunction
  // ====================
  // scenarios
  task automatic compare_sweep;
    logic [6:0]  opc [3] = '{7'h31, 7'h32, 7'h30};
    logic        a_t [4] = '{1'b0, 1'b1, 1'b0, 1'b0};
    logic        x_t [4] = '{1'b0, 1'b0, 1'b1, 1'b1};
    logic [7:0]  f_t [4] = '{8'h00, 8'h9C, 8'h5F, 8'h60};
    logic [11:0] ea [4] = '{12'h000, 12'h39C, 12'h182, 12'hF60};
    logic [7:0]  dv [3] = '{8'h00, 8'h01, 8'hFF};
    int n;
    for (int o = 0; o < 3; o++) for (int r = 0; r < 4; r++) for (int d = 0; d < 3; d++) begin
      f = pat(ea[r]);
      wv = f + dv[d];
      sk = (o == 0) ? (f == wv) : (o == 1) ? (f > wv) : (f < wv);
      n = sk ? (r[0] ? 3 : 2) : 1;
      w <= wv;
      ext <= x_t[r];
      issue({opc[o], a_t[r], f_t[r]}, r[0], n);
      chk(12'(fl), 12'(4 * (n - 1)));
      chk({mw, ww, fw}, 12'h000);
      chk(got_addr, ea[r]);
      chk(12'(eph), 12'h003);
      issue(16'h0000, 1'b0, 1);
      chk(12'(fl), 12'h000);
    end
  endtask
  task automatic complement_dest;
    bank <= 4'h2;
    ext <= 1'b0;
    issue(16'h1F55, 1'b0, 1);
    chk({mw, ww, fw}, 12'h101);
    chk({2'b00, dat, nz}, 12'h222);
    w <= 8'h88;
    issue(16'h6355, 1'b0, 2);
    chk(12'(fl), 12'h004);
    chk({mw, ww, fw}, 12'h000);
    bank <= 4'h0;
    issue(16'h1DFF, 1'b0, 1);
    chk({mw, ww, fw}, 12'h011);
    chk({2'b00, dat, nz}, 12'h001);
  endtask
  // reset dropped in the middle of a skipped slot must clear it at once
  task automatic reset_midway;
    int k;
    w <= 8'h00;
    ext <= 1'b0;
    iw <= 16'h6200;
    for (k = 0; k < 20 && flush !== 1'b1; k++) @(posedge core_clk);
    chk(12'(flush), 12'h001);
    iw <= 16'h0000;
    rstn <= 1'b0;
    @(posedge core_clk);
    chk({4'h0, ph, send, flush, mrd, mwe, wwe, fwe}, 12'h000);
    chk(addr, 12'h000);
    rstn <= 1'b1;
    repeat (2) @(posedge core_clk);
  endtask
  initial begin
    repeat (5) @(posedge core_clk);
    rstn <= 1'b1;
    repeat (2) @(posedge core_clk);
    compare_sweep();
    reset_midway();
    complement_dest();
    end_of_test();
  end
endmodule // compare_skip_instruction_exec_tb_top
`default_nettype wire
